// *** rtl/mii_strap_pkg.sv ***
package mii_strap_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int LINK_PERIOD_NS = 320;
    // half period of the generated link clock, rounded down
    localparam int LINK_HALF_CYC  = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int SETTLE_CYCLES  = 2;

    // ----------------------------------------------------------------
    // strap vector positions
    // ----------------------------------------------------------------
    localparam int STRAP_P5_B0  = 0;
    localparam int STRAP_P5_B1  = 1;
    localparam int STRAP_P5_B2  = 2;
    localparam int STRAP_P5_B3  = 3;
    localparam int STRAP_P5_ERR = 4;
    localparam int STRAP_P5_CRS = 5;
    localparam int STRAP_P5_COL = 6;
    localparam int STRAP_SW_B2  = 7;
    localparam int STRAP_SW_B3  = 8;
    localparam int STRAP_W      = 9;

    localparam logic [2:0] CFG_DISABLE = 3'h0;
    localparam logic [2:0] CFG_PHY_MII = 3'h1;
    localparam logic [2:0] CFG_MAC_MII = 3'h2;
    localparam logic [2:0] CFG_PHY_SNI = 3'h3;
    localparam int         CFG_P5_EN   = 2;

    localparam logic [10:0] FRAME_LEN_UNTAG = 11'd1518;
    localparam logic [10:0] FRAME_LEN_TAG   = 11'd1522;
    localparam logic [10:0] FRAME_LEN_LONG  = 11'd1536;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_STRAP  = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_P5OUT  = 8'h08;
    localparam logic [7:0] ADDR_SWOUT  = 8'h0c;
    localparam logic [7:0] ADDR_RXDATA = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    localparam int STRAP_CFG_LSB = 12;
    localparam int STRAP_DONE    = 15;
    localparam int CTRL_CAPTURE  = 0;
    localparam int P5_NIB_LSB    = 0;
    localparam int P5_VALID      = 4;
    localparam int P5_ERR        = 5;
    localparam int P5_CRS        = 6;
    localparam int P5_COL        = 7;
    localparam int SW_VALID      = 0;
    localparam int SW_NIB_LSB    = 1;
    localparam int RX_VALID      = 8;
    localparam int STAT_NONEMPTY = 0;
    localparam int STAT_OVERFLOW = 1;

    localparam logic       CTRL_RST  = 1'b1;
    localparam logic [7:0] P5OUT_RST = 8'h00;
    localparam logic [2:0] SWOUT_RST = 3'h0;

    typedef enum logic [1:0] {MODE_OFF, MODE_PHY, MODE_MAC} swmode_t;
    typedef enum logic [1:0] {ST_SETTLE, ST_SAMPLE, ST_RUN} strapstate_t;

endpackage

// *** rtl/bit_sync.sv ***
`timescale 1ns/1ns
module bit_sync
    import mii_strap_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_ff   <= '0;
            stable_ff <= '0;
        end else begin
            meta_ff   <= asyncIn;
            stable_ff <= meta_ff;
        end
    end

    assign syncOut = stable_ff;
endmodule // bit_sync

// *** rtl/sync_fifo.sv ***
`timescale 1ns/1ns
module sync_fifo
    import mii_strap_pkg::*;
#(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_ff;
    logic [AW:0]      rdPtr_ff;

    wire full  = (wrPtr_ff[AW] != rdPtr_ff[AW]) &&
                 (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
    wire empty = (wrPtr_ff == rdPtr_ff);
    wire push  = inValid & ~full;
    wire pop   = outReady & ~empty;

    assign inReady  = ~full;
    assign outValid = ~empty;
    assign outData  = mem[rdPtr_ff[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end else begin
            wrPtr_ff <= wrPtr_ff + (AW+1)'(push);
            rdPtr_ff <= rdPtr_ff + (AW+1)'(pop);
        end
    end
endmodule // sync_fifo

// *** rtl/mii_strap_config_pins.sv ***
// Behaviour
// - strap pins are inputs in reset, then outputs where the config strap enables port 5 or a switch mode
// - port-5 bit-3 strap low enables flow control
// - port-5 bit-2 strap high enables back pressure
// - port-5 bit-1 strap high keeps excess-collision packets
// - port-5 bit-0 strap high selects aggressive back-off
// - port-5 error strap selects 1518/1522 or 1536
// - carrier strap forces port-4 duplex on fallback
// - collision strap high forces port-4 flow control
// - switch clocks input in MAC, output in PHY
// - switch bit-3 strap high enables switch flow control
// - switch bit-2 strap high selects half duplex
// - port-5 drives valid, nibble, error, carrier, collision
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module mii_strap_config_pins
    import mii_strap_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // straps and pins
    input  wire logic [2:0]  dualPortCfgStrap,
    output logic             strapPullDownEn,
    output logic             p5RxValidOut,
    output logic             p5RxValidOe,
    input  wire logic [3:0]  p5RxNibbleIn,
    output logic      [3:0]  p5RxNibbleOut,
    output logic      [3:0]  p5RxNibbleOe,
    input  wire logic        p5RxErrorIn,
    output logic             p5RxErrorOut,
    output logic             p5RxErrorOe,
    input  wire logic        p5CarrierSenseIn,
    output logic             p5CarrierSenseOut,
    output logic             p5CarrierSenseOe,
    input  wire logic        p5CollisionIn,
    output logic             p5CollisionOut,
    output logic             p5CollisionOe,
    input  wire logic        swTxEnable,
    input  wire logic [3:0]  swTxNibble,
    input  wire logic        swTxError,
    input  wire logic        swTxClockIn,
    output logic             swTxClockOut,
    output logic             swTxClockOe,
    input  wire logic        swRxClockIn,
    output logic             swRxClockOut,
    output logic             swRxClockOe,
    output logic             swRxValidOut,
    output logic             swRxValidOe,
    input  wire logic [3:2]  swRxNibbleIn,
    output logic      [3:2]  swRxNibbleOut,
    output logic      [3:2]  swRxNibbleOe,
    // decoded configuration
    output logic             flowCtrlEn,
    output logic             backPressEn,
    output logic             keepExcessCol,
    output logic             aggrBackoff,
    output logic      [10:0] maxFrameUntag,
    output logic      [10:0] maxFrameTag,
    output logic             p4ForceFullDuplex,
    output logic             p4ForceFlowCtrl,
    output logic             swFlowCtrlEn,
    output logic             swHalfDuplex,
    output swmode_t          swMode
);
    localparam int SYNC_W = STRAP_W + 3 + 1 + 6;
    localparam int DIV_W  = $clog2(LINK_HALF_CYC + 1);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] syncVec;
    bit_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .asyncIn ({swTxEnable, swTxError, swTxNibble, swTxClockIn,
                   dualPortCfgStrap, swRxNibbleIn, p5CollisionIn,
                   p5CarrierSenseIn, p5RxErrorIn, p5RxNibbleIn}),
        .syncOut (syncVec)
    );
    wire [STRAP_W-1:0] strapSync = syncVec[STRAP_W-1:0];
    wire [2:0]         cfgSync   = syncVec[STRAP_W +: 3];
    wire               txClkSync = syncVec[STRAP_W + 3];
    wire [5:0]         txSync    = syncVec[SYNC_W-1 -: 6];

    // ----------------------------------------------------------------
    // strap capture sequencer
    // ----------------------------------------------------------------
    strapstate_t  strapState_ff;
    logic [1:0]   settleCnt_ff;
    logic         strapDone_ff;
    logic [STRAP_W-1:0] strapCap_ff;
    logic [2:0]   cfgCap_ff;
    swmode_t      swMode_ff;
    logic         p5Oe_ff;
    logic         swDataOe_ff;
    logic         swClkOe_ff;

    wire settleDone = settleCnt_ff == 2'(SETTLE_CYCLES - 1);
    wire capture    = strapState_ff == ST_SAMPLE;

    // only the low two bits pick the switch mode; the top bit gates port 5
    swmode_t modeDecode;
    always_comb begin
        case (cfgSync[1:0])
            CFG_PHY_MII[1:0]: modeDecode = MODE_PHY;
            CFG_MAC_MII[1:0]: modeDecode = MODE_MAC;
            CFG_PHY_SNI[1:0]: modeDecode = MODE_PHY;
            default:          modeDecode = MODE_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            strapState_ff <= ST_SETTLE;
            settleCnt_ff  <= 2'h0;
        end else begin
            case (strapState_ff)
                ST_SETTLE: begin
                    settleCnt_ff <= settleCnt_ff + 2'h1;
                    if (settleDone) begin
                        strapState_ff <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: strapState_ff <= ST_RUN;
                ST_RUN:    strapState_ff <= ST_RUN;
                default:   strapState_ff <= ST_SETTLE;
            endcase
        end
    end

    // latched once; pins turning into outputs cannot disturb it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            strapDone_ff <= 1'b0;
            strapCap_ff  <= '0;
            cfgCap_ff    <= 3'h0;
            swMode_ff    <= MODE_OFF;
            p5Oe_ff      <= 1'b0;
            swDataOe_ff  <= 1'b0;
            swClkOe_ff   <= 1'b0;
        end else if (capture) begin
            strapDone_ff <= 1'b1;
            strapCap_ff  <= strapSync;
            cfgCap_ff    <= cfgSync;
            swMode_ff    <= modeDecode;
            p5Oe_ff      <= cfgSync[CFG_P5_EN];
            swDataOe_ff  <= modeDecode != MODE_OFF;
            swClkOe_ff   <= modeDecode == MODE_PHY;
        end
    end

    // ----------------------------------------------------------------
    // decoded configuration
    // ----------------------------------------------------------------
    assign flowCtrlEn      = ~strapCap_ff[STRAP_P5_B3];
    assign backPressEn     = strapCap_ff[STRAP_P5_B2];
    assign keepExcessCol   = strapCap_ff[STRAP_P5_B1];
    assign aggrBackoff     = strapCap_ff[STRAP_P5_B0];
    assign maxFrameUntag   = strapCap_ff[STRAP_P5_ERR] ?
                             FRAME_LEN_LONG : FRAME_LEN_UNTAG;
    assign maxFrameTag     = strapCap_ff[STRAP_P5_ERR] ?
                             FRAME_LEN_LONG : FRAME_LEN_TAG;
    assign p4ForceFullDuplex = strapCap_ff[STRAP_P5_CRS];
    assign p4ForceFlowCtrl = strapCap_ff[STRAP_P5_COL];
    assign swFlowCtrlEn    = strapCap_ff[STRAP_SW_B3];
    assign swHalfDuplex    = strapCap_ff[STRAP_SW_B2];
    assign swMode          = swMode_ff;

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    logic        wrEn_ff;
    logic [7:0]  wrAddr_ff;
    logic [31:0] hrdata_ff;
    logic        captureEn_ff;
    logic [7:0]  p5Out_ff;
    logic [2:0]  swOut_ff;
    logic        overflow_ff;
    logic        fifoOutValid;
    logic [4:0]  fifoOutData;
    logic        fifoInReady;

    wire accept  = hsel & hready & htrans[1];
    wire rdNow   = accept & ~hwrite;
    wire wrCtrl  = wrEn_ff & (wrAddr_ff[7:2] == ADDR_CTRL[7:2]);
    wire wrP5    = wrEn_ff & (wrAddr_ff[7:2] == ADDR_P5OUT[7:2]);
    wire wrSw    = wrEn_ff & (wrAddr_ff[7:2] == ADDR_SWOUT[7:2]);
    wire wrStat  = wrEn_ff & (wrAddr_ff[7:2] == ADDR_STATUS[7:2]);
    wire popRx   = rdNow & (haddr[7:2] == ADDR_RXDATA[7:2]);

    // a write to CTRL, P5OUT or SWOUT still in its data phase is forwarded to a following read
    wire        ctrlView = wrCtrl ? hwdata[CTRL_CAPTURE] : captureEn_ff;
    wire [7:0]  p5View   = wrP5 ? hwdata[7:0] : p5Out_ff;
    wire [2:0]  swView   = wrSw ? hwdata[2:0] : swOut_ff;
    wire [31:0] strapWord = {16'h0000, strapDone_ff, cfgCap_ff,
                             3'h0, strapCap_ff};
    wire [31:0] rxWord   = {23'h000000, fifoOutValid, 3'h0, fifoOutData};
    wire [31:0] statWord = {30'h00000000, overflow_ff, fifoOutValid};
    wire [31:0] rdMux =
        (haddr[7:2] == ADDR_STRAP[7:2])  ? strapWord :
        (haddr[7:2] == ADDR_CTRL[7:2])   ? {31'h00000000, ctrlView} :
        (haddr[7:2] == ADDR_P5OUT[7:2])  ? {24'h000000, p5View} :
        (haddr[7:2] == ADDR_SWOUT[7:2])  ? {29'h00000000, swView} :
        (haddr[7:2] == ADDR_RXDATA[7:2]) ? rxWord :
        (haddr[7:2] == ADDR_STATUS[7:2]) ? statWord : 32'h00000000;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrEn_ff   <= 1'b0;
            wrAddr_ff <= 8'h00;
            hrdata_ff <= 32'h00000000;
        end else begin
            wrEn_ff   <= accept & hwrite;
            wrAddr_ff <= haddr;
            hrdata_ff <= rdNow ? rdMux : 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            captureEn_ff <= CTRL_RST;
            p5Out_ff     <= P5OUT_RST;
            swOut_ff     <= SWOUT_RST;
        end else begin
            captureEn_ff <= ctrlView;
            p5Out_ff     <= p5View;
            swOut_ff     <= swView;
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    logic pullEn_ff;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pullEn_ff <= 1'b1;
        end else begin
            pullEn_ff <= ~(capture | strapDone_ff);
        end
    end
    assign strapPullDownEn   = pullEn_ff;

    assign p5RxValidOut      = p5Out_ff[P5_VALID];
    assign p5RxNibbleOut     = p5Out_ff[P5_NIB_LSB +: 4];
    assign p5RxErrorOut      = p5Out_ff[P5_ERR];
    assign p5CarrierSenseOut = p5Out_ff[P5_CRS];
    assign p5CollisionOut    = p5Out_ff[P5_COL];
    assign p5RxValidOe       = p5Oe_ff;
    assign p5RxNibbleOe      = {4{p5Oe_ff}};
    assign p5RxErrorOe       = p5Oe_ff;
    assign p5CarrierSenseOe  = p5Oe_ff;
    assign p5CollisionOe     = p5Oe_ff;
    assign swRxValidOut      = swOut_ff[SW_VALID];
    assign swRxNibbleOut     = swOut_ff[SW_NIB_LSB +: 2];
    assign swRxValidOe       = swDataOe_ff;
    assign swRxNibbleOe      = {2{swDataOe_ff}};
    assign swTxClockOe       = swClkOe_ff;
    assign swRxClockOe       = swClkOe_ff;

    // ----------------------------------------------------------------
    // switch-side link capture
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] divCnt_ff;
    logic             linkClk_ff;
    logic             txClkPrev_ff;
    logic [5:0]       txPrev_ff;

    wire phyRun  = strapDone_ff & (swMode_ff == MODE_PHY);
    wire macRun  = strapDone_ff & (swMode_ff == MODE_MAC);
    wire divWrap = divCnt_ff == DIV_W'(LINK_HALF_CYC - 1);
    wire phyRise = phyRun & divWrap & ~linkClk_ff;
    wire macRise = macRun & txClkSync & ~txClkPrev_ff;
    // data one cycle older than the edge, so a change on the edge is missed
    wire txActive = txPrev_ff[5] | txPrev_ff[4];
    wire pushReq  = (phyRise | macRise) & captureEn_ff & txActive;
    wire lost     = pushReq & ~fifoInReady;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            divCnt_ff    <= '0;
            linkClk_ff   <= 1'b0;
            txClkPrev_ff <= 1'b0;
            txPrev_ff    <= 6'h00;
        end else begin
            divCnt_ff    <= (phyRun & ~divWrap) ? divCnt_ff + DIV_W'(1)
                                                : '0;
            linkClk_ff   <= phyRun & (linkClk_ff ^ divWrap);
            txClkPrev_ff <= txClkSync;
            txPrev_ff    <= txSync;
        end
    end
    assign swTxClockOut = linkClk_ff;
    assign swRxClockOut = linkClk_ff;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            overflow_ff <= 1'b0;
        end else begin
            overflow_ff <= lost |
                           (overflow_ff & ~(wrStat & hwdata[STAT_OVERFLOW]));
        end
    end

    sync_fifo #(.WIDTH(5), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .inValid  (pushReq),
        .inReady  (fifoInReady),
        .inData   (txPrev_ff[4:0]),
        .outValid (fifoOutValid),
        .outReady (popRx),
        .outData  (fifoOutData)
    );

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence sSample;
        strapState_ff == ST_SAMPLE;
    endsequence
    sequence sCapture;
        sSample ##1 strapDone_ff;
    endsequence

    AST_PINS_IN_RESET: assert property (
        !strapDone_ff |-> !p5Oe_ff && !swDataOe_ff && pullEn_ff)
        else $error("strap pin driven before capture");
    AST_PINS_DRIVEN: assert property (
        sCapture |-> !pullEn_ff && p5Oe_ff == $past(cfgSync[CFG_P5_EN]))
        else $error("strap pin not turned to output");
    AST_SETTLE_BOUND: assert property (
        $rose(nrst) |-> ##[1:4] strapDone_ff)
        else $error("strap capture too late");
    AST_FLOW_CTRL: assert property (
        sCapture |-> flowCtrlEn == !$past(strapSync[STRAP_P5_B3]))
        else $error("flow control strap wrong");
    AST_BACK_PRESS: assert property (
        sCapture |-> backPressEn == $past(strapSync[STRAP_P5_B2]))
        else $error("back pressure strap wrong");
    AST_EXCESS_COL: assert property (
        sCapture |-> keepExcessCol == $past(strapSync[STRAP_P5_B1]))
        else $error("collision drop strap wrong");
    AST_BACKOFF: assert property (
        sCapture |-> aggrBackoff == $past(strapSync[STRAP_P5_B0]))
        else $error("back-off strap wrong");
    AST_FRAME_LEN: assert property (
        sCapture |-> $past(strapSync[STRAP_P5_ERR]) ?
            maxFrameTag == 11'd1536 && maxFrameUntag == 11'd1536 :
            maxFrameTag == 11'd1522 && maxFrameUntag == 11'd1518)
        else $error("frame limit wrong");
    AST_P4_FORCE: assert property (
        sCapture |-> p4ForceFullDuplex == $past(strapSync[STRAP_P5_CRS])
            && p4ForceFlowCtrl == $past(strapSync[STRAP_P5_COL]))
        else $error("port-4 force strap wrong");
    AST_SW_STRAPS: assert property (
        sCapture |-> swFlowCtrlEn == $past(strapSync[STRAP_SW_B3])
            && swHalfDuplex == $past(strapSync[STRAP_SW_B2]))
        else $error("switch strap wrong");
    AST_SW_CLK_DIR: assert property (
        strapDone_ff |-> swTxClockOe == (swMode_ff == MODE_PHY)
            && swRxClockOe == swTxClockOe)
        else $error("switch clock direction wrong");
    AST_P5_DRIVE: assert property (
        wrP5 |=> p5RxNibbleOut == $past(hwdata[3:0])
            && p5CollisionOut == $past(hwdata[P5_COL]))
        else $error("port-5 pins not following register");
    AST_HOLD: assert property (
        strapDone_ff |=> $stable(strapCap_ff) && $stable(swMode_ff))
        else $error("latched straps changed");
endmodule // mii_strap_config_pins

// *** verification/mii_mac_model.sv ***
`timescale 1ns/1ns
module mii_mac_model (
    input  wire logic       go,
    output logic            txEnable,
    output logic      [3:0] txNibble,
    output logic            txError,
    output logic            txClock
);
    initial begin
        {txEnable, txNibble, txError, txClock} = 7'h00;
        forever begin
            @(posedge go);
            // keep the link clock edges off the system clock edges
            #10;
            // 18 nibbles: two more than the buffer holds
            for (int i = 0; i < 18; i++) begin
                txEnable = 1'b1;
                txNibble = i[3:0];
                txError  = (i == 5);
                #160 txClock = 1'b1;
                #160 txClock = 1'b0;
            end
            // the model drives the lines low again once the last nibble has been sent
            {txEnable, txNibble, txError} = 6'h00;
        end
    end
endmodule // mii_mac_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
module tb_top import mii_strap_pkg::*;;
    logic        clk_sys = 1'b0, nrst = 1'b0, go = 1'b0;
    logic        hsel = 1'b1, hwrite = 1'b0, swRxClockIn = 1'b0;
    logic [2:0]  hsize = 3'h2, dualPortCfgStrap = 3'h0;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  haddr = 8'h00;
    logic [8:0]  strap = 9'h000;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic        hready, hreadyout, hresp, strapPullDownEn;
    logic        p5RxValidOut, p5RxValidOe, p5RxErrorOut, p5RxErrorOe;
    logic        p5CarrierSenseOut, p5CarrierSenseOe, p5CollisionOut;
    logic        p5CollisionOe, p5RxErrorIn, p5CarrierSenseIn;
    logic        p5CollisionIn, swTxEnable, swTxError, swTxClockIn;
    logic        swTxClockOut, swTxClockOe, swRxClockOut, swRxClockOe;
    logic        swRxValidOut, swRxValidOe, flowCtrlEn, backPressEn;
    logic        keepExcessCol, aggrBackoff, p4ForceFullDuplex;
    logic        p4ForceFlowCtrl, swFlowCtrlEn, swHalfDuplex;
    logic [3:0]  p5RxNibbleIn, p5RxNibbleOut, p5RxNibbleOe, swTxNibble;
    logic [3:2]  swRxNibbleIn, swRxNibbleOut, swRxNibbleOe;
    logic [10:0] maxFrameUntag, maxFrameTag;
    swmode_t     swMode;
    int          errors = 0, compares = 0;
    wire logic [13:0] allOe = {p5RxValidOe, p5RxNibbleOe, p5RxErrorOe,
        p5CarrierSenseOe, p5CollisionOe, swRxValidOe, swRxNibbleOe,
        swTxClockOe, swRxClockOe, strapPullDownEn};
    wire logic [10:0] pinOut = {p5RxValidOut, p5RxNibbleOut, p5RxErrorOut,
        p5CarrierSenseOut, p5CollisionOut, swRxValidOut, swRxNibbleOut};
    wire logic [29:0] cfgOut = {flowCtrlEn, backPressEn, keepExcessCol,
        aggrBackoff, p4ForceFullDuplex, p4ForceFlowCtrl, swFlowCtrlEn,
        swHalfDuplex, maxFrameUntag, maxFrameTag};

    // a pin shows the design's level while driven, else its strap resistor
    assign p5RxNibbleIn = p5RxNibbleOe & p5RxNibbleOut
                        | ~p5RxNibbleOe & strap[3:0];
    assign swRxNibbleIn = swRxNibbleOe & swRxNibbleOut
                        | ~swRxNibbleOe & strap[8:7];
    assign p5RxErrorIn = p5RxErrorOe ? p5RxErrorOut : strap[4];
    assign p5CarrierSenseIn = p5CarrierSenseOe ? p5CarrierSenseOut : strap[5];
    assign p5CollisionIn = p5CollisionOe ? p5CollisionOut : strap[6];
    assign hready = hreadyout;

    always #20 clk_sys = ~clk_sys;

    mii_strap_config_pins #(.FIFO_DEPTH(16)) i_dut (.*);
    mii_mac_model i_mac (.go(go), .txEnable(swTxEnable),
        .txNibble(swTxNibble), .txError(swTxError), .txClock(swTxClockIn));

    task automatic chk(input logic [31:0] exp, input logic [31:0] act);
        compares++;
        if (act !== exp) begin
            errors++;
            $display("ERROR %0t exp %h got %h", $time, exp, act);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = hrdata;
        chk(32'h0, hresp);
    endtask

    task automatic boot(input logic [8:0] s, input logic [2:0] c);
        logic [1:0]  m;
        logic [29:0] e;
        logic [10:0] k;
        logic [7:0]  v;
        logic [7:0]  w;
        m = (c[1:0] == 2'h3) ? 2'h1 : c[1:0];
        k = {{8{c[2]}}, {3{c[1:0] != 2'h0}}};
        e = {~s[3], s[2:0], s[5], s[6], s[8], s[7],
             s[4] ? {2{11'h600}} : {11'h5ee, 11'h5f2}};
        strap <= s;
        dualPortCfgStrap <= c;
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(32'h1, allOe);
        nrst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk({k, {2{m == 2'h1}}, 1'b0}, allOe);
        chk(m, swMode);
        for (int j = 0; j < 8; j++) begin
            @(posedge clk_sys);
            v[j] = swTxClockOut;
            w[j] = swRxClockOut;
        end
        chk((m == 2'h1) ? 32'h4 : 32'h0, $countones(v));
        chk(v, w);
        chk(e, cfgOut);
        ahb(1'b0, 8'h00, 32'h0, rd);
        chk({16'h0, 1'b1, c, 3'h0, s}, rd);
        ahb(1'b1, 8'h08, 32'hff, rd);
        ahb(1'b1, 8'h0c, 32'h7, rd);
        repeat (2) @(posedge clk_sys);
        chk(32'h7ff, pinOut);
        chk(e, cfgOut);
        ahb(1'b1, 8'h08, 32'h0, rd);
        ahb(1'b1, 8'h0c, 32'h0, rd);
        repeat (2) @(posedge clk_sys);
        chk(32'h0, pinOut);
        chk(e, cfgOut);
    endtask

    task automatic link;
        go <= 1'b1;
        repeat (160) @(posedge clk_sys);
        go <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            ahb(1'b0, 8'h10, 32'h0, rd);
            chk({23'h0, 1'b1, 3'h0, i == 5, i[3:0]}, rd);
        end
        ahb(1'b0, 8'h14, 32'h0, rd);
        chk(32'h2, rd);
        ahb(1'b1, 8'h14, 32'h2, rd);
        ahb(1'b0, 8'h14, 32'h0, rd);
        chk(32'h0, rd);
        ahb(1'b0, 8'h04, 32'h0, rd);
        chk(32'h1, rd);
        ahb(1'b0, 8'h18, 32'h0, rd);
        chk(32'h0, rd);
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        boot(9'h000, 3'h4);
        boot(9'h1ff, 3'h5);
        boot(9'h15a, 3'h7);
        boot(9'h0f0, 3'h0);
        boot(9'h0a5, 3'h6);
        link();
        tally_and_finish();
    end

    initial begin
        repeat (4000) @(posedge clk_sys);
        errors++;
        tally_and_finish();
    end
endmodule // tb_top
